// file: pcls_pkg.sv
// constants, state codes and carrier types of the parallel configuration load sequencer
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package pcls_pkg;

  // ----------------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 20;
  localparam int REQ_TO_LOW_NS   = 600;
  localparam int REQ_TO_LOW_CYC  = REQ_TO_LOW_NS / CLK_PERIOD_NS;
  localparam int STATUS_MIN_US   = 268;
  localparam int STATUS_MIN_CYC  = (STATUS_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STATUS_MAX_US   = 1506;
  localparam int STATUS_MAX_CYC  = (STATUS_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int INIT_MIN_US     = 175;
  localparam int INIT_MAX_US     = 437;
  localparam int INIT_OSC_CYC    = (INIT_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_MAX_CYC    = (INIT_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int UCLK_INIT_EDGES = 8576;
  localparam int DONE_FALL_EDGES = 2;
  localparam int CNT_W           = 20;
  localparam int WORDS_W         = 24;

  // ----------------------------------------------------------------------------
  // data path
  // ----------------------------------------------------------------------------
  localparam int DATA_W     = 32;
  localparam int FIFO_DEPTH = 16;
  localparam logic [1:0] BW_8  = 2'h0;
  localparam logic [1:0] BW_16 = 2'h1;
  localparam logic [1:0] BW_32 = 2'h2;
  localparam logic [DATA_W-1:0] MASK_8  = 32'h0000_00ff;
  localparam logic [DATA_W-1:0] MASK_16 = 32'h0000_ffff;
  localparam logic [DATA_W-1:0] MASK_32 = 32'hffff_ffff;

  typedef enum logic [2:0] {
    ST_HOLD  = 3'h0,
    ST_WAIT  = 3'h1,
    ST_LOAD  = 3'h2,
    ST_INIT  = 3'h3,
    ST_USER  = 3'h4,
    ST_ERROR = 3'h5
  } pcls_state_t;

  typedef struct packed {
    logic              req_n;
    logic              cfg_clock;
    logic              status_n;
    logic              user_init_clock;
    logic              use_user_clock;
    logic [1:0]        width;
    logic [DATA_W-1:0] data;
  } pcls_pins_t;

  typedef struct packed {
    logic [1:0]        width;
    logic [DATA_W-1:0] data;
  } pcls_word_t;

  localparam int PINS_W = $bits(pcls_pins_t);
  localparam int WORD_W = $bits(pcls_word_t);

endpackage

// file: pcls_sync.sv
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/10ps
module pcls_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  import pcls_pkg::*;

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } pcls_sync_t;

  pcls_sync_t r;
  pcls_sync_t next_r;

  // the first stage feeds only the second stage
  always_comb begin
    next_r.meta   = async_i;
    next_r.stable = r.meta;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign sync_o = r.stable;
endmodule

// file: pcls_fifo.sv
// word buffer with valid/ready on both sides and a registered read port
`timescale 1ns/10ps
module pcls_fifo #(
  parameter int W     = 34,
  parameter int DEPTH = 16
) (
  input  wire logic         core_clk_i,
  input  wire logic         rstn_i,
  input  wire logic         flush_i,
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  output logic      [W-1:0] out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  import pcls_pkg::*;

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr_ptr;
    logic [AW-1:0]           rd_ptr;
    logic [AW:0]             count;
    logic [W-1:0]            out_data;
    logic                    out_valid;
  } pcls_fifo_t;

  pcls_fifo_t r;
  pcls_fifo_t next_r;
  logic       push;
  logic       pop;

  always_comb begin
    next_r = r;
    push   = in_valid_i && (r.count != (AW + 1)'(DEPTH));
    // the output register refills from a non-empty buffer whenever it is empty or being taken
    pop    = (r.count != '0) && (!r.out_valid || out_ready_i);
    if (push) begin
      next_r.mem[r.wr_ptr] = in_data_i;
      next_r.wr_ptr        = r.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_r.out_data = r.mem[r.rd_ptr];
      next_r.rd_ptr   = r.rd_ptr + 1'b1;
    end
    if (pop) begin
      next_r.out_valid = 1'b1;
    end else if (out_ready_i) begin
      next_r.out_valid = 1'b0;
    end
    next_r.count = r.count + (AW + 1)'(push) - (AW + 1)'(pop);
    if (flush_i) begin
      next_r.wr_ptr    = '0;
      next_r.rd_ptr    = '0;
      next_r.count     = '0;
      next_r.out_valid = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign in_ready_o  = (r.count != (AW + 1)'(DEPTH));
  assign out_data_o  = r.out_data;
  assign out_valid_o = r.out_valid;
endmodule

// file: pcls_loader.sv
// device-side sequencer for the fast parallel configuration load
`timescale 1ns/10ps
module pcls_loader #(
  parameter int STATUS_MIN   = pcls_pkg::STATUS_MIN_CYC,
  parameter int INIT_OSC     = pcls_pkg::INIT_OSC_CYC,
  parameter int UCLK_EDGES   = pcls_pkg::UCLK_INIT_EDGES,
  parameter int STREAM_WORDS = 1024
) (
  input  wire logic                    core_clk_i,
  input  wire logic                    rstn_i,
  input  wire logic                    cfg_req_n_i,
  input  wire logic                    cfg_clock_i,
  input  wire logic [pcls_pkg::DATA_W-1:0] cfg_data_i,
  input  wire logic [1:0]              bus_width_i,
  input  wire logic                    status_n_i,
  output logic                         status_n_o,
  output logic                         status_oe_n_o,
  output logic                         load_done_o,
  input  wire logic                    user_init_clock_i,
  input  wire logic                    use_user_clock_i,
  output logic                         user_mode_o,
  output logic                         load_error_o,
  output pcls_pkg::pcls_word_t         word_o,
  output logic                         word_valid_o,
  input  wire logic                    word_ready_i
);
  import pcls_pkg::*;

  typedef struct packed {
    pcls_state_t        state;
    logic [CNT_W-1:0]   cnt;
    logic [WORDS_W-1:0] words;
    logic [1:0]         falls;
    logic               prev_req_n;
    logic               prev_cfg_clock;
    logic               prev_uclk;
    logic               status_drive_n;
    logic               status_level;
    logic               done;
    logic               user;
    logic               error;
    logic               push;
    pcls_word_t         word;
  } pcls_loader_t;

  pcls_loader_t r;
  pcls_loader_t next_r;
  pcls_pins_t   raw_pins;
  pcls_pins_t   pins;
  logic         fifo_ready;
  logic         req_low;
  logic         cclk_rise;
  logic         cclk_fall;
  logic         uclk_rise;
  logic [DATA_W-1:0] mask;

  // ----------------------------------------------------------------------------
  // pin capture
  // ----------------------------------------------------------------------------
  always_comb begin
    raw_pins.req_n           = cfg_req_n_i;
    raw_pins.cfg_clock       = cfg_clock_i;
    raw_pins.status_n        = status_n_i;
    raw_pins.user_init_clock = user_init_clock_i;
    raw_pins.use_user_clock  = use_user_clock_i;
    raw_pins.width           = bus_width_i;
    raw_pins.data            = cfg_data_i;
  end

  // data and clock share one synchroniser so a sampled edge lines up with its word
  pcls_sync #(
    .W(PINS_W)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .rstn_i    (rstn_i),
    .async_i   (raw_pins),
    .sync_o    (pins)
  );

  // ----------------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------------
  always_comb begin
    next_r              = r;
    next_r.prev_req_n   = pins.req_n;
    next_r.prev_cfg_clock = pins.cfg_clock;
    next_r.prev_uclk    = pins.user_init_clock;
    next_r.status_level = 1'b0;
    next_r.push         = 1'b0;
    req_low   = !pins.req_n;
    cclk_rise = pins.cfg_clock && !r.prev_cfg_clock;
    cclk_fall = !pins.cfg_clock && r.prev_cfg_clock;
    uclk_rise = pins.user_init_clock && !r.prev_uclk;
    case (pins.width)
      BW_8:    mask = MASK_8;
      BW_16:   mask = MASK_16;
      default: mask = MASK_32;
    endcase

    case (r.state)
      ST_HOLD: begin
        // the low time counts from the request fall; a long request extends it
        if (r.cnt != '1) begin
          next_r.cnt = r.cnt + 1'b1;
        end
        if (!req_low && (r.cnt >= CNT_W'(STATUS_MIN - 1))) begin
          next_r.state          = ST_WAIT;
          next_r.status_drive_n = 1'b1;
        end
      end
      ST_WAIT: begin
        // an outside party may keep the line low; no time limit applies here
        if (pins.status_n) begin
          next_r.state = ST_LOAD;
          next_r.words = '0;
        end
      end
      ST_LOAD: begin
        if (cclk_rise) begin
          if (fifo_ready) begin
            next_r.push       = 1'b1;
            next_r.word.width = pins.width;
            next_r.word.data  = pins.data & mask;
            next_r.words      = r.words + 1'b1;
            if (r.words == WORDS_W'(STREAM_WORDS - 1)) begin
              next_r.state = ST_INIT;
              next_r.done  = 1'b1;
              next_r.falls = '0;
              next_r.cnt   = '0;
            end
          end else begin
            // the host clock cannot be stalled, so a full buffer loses a word
            next_r.state          = ST_ERROR;
            next_r.error          = 1'b1;
            next_r.status_drive_n = 1'b0;
          end
        end
      end
      ST_INIT: begin
        if (r.falls != 2'(DONE_FALL_EDGES)) begin
          if (cclk_fall) begin
            next_r.falls = r.falls + 1'b1;
          end
        end else if (pins.use_user_clock) begin
          if (uclk_rise) begin
            next_r.cnt = r.cnt + 1'b1;
            if (r.cnt == CNT_W'(UCLK_EDGES - 1)) begin
              next_r.state = ST_USER;
              next_r.user  = 1'b1;
            end
          end
        end else begin
          next_r.cnt = r.cnt + 1'b1;
          if (r.cnt == CNT_W'(INIT_OSC - 1)) begin
            next_r.state = ST_USER;
            next_r.user  = 1'b1;
          end
        end
      end
      ST_USER: begin
        next_r.user = 1'b1;
      end
      ST_ERROR: begin
        next_r.status_drive_n = 1'b0;
      end
      default: begin
        next_r.state = ST_HOLD;
      end
    endcase

    // a low request restarts everything from any state
    if (req_low && (r.state != ST_HOLD)) begin
      next_r.state          = ST_HOLD;
      next_r.cnt            = '0;
      next_r.done           = 1'b0;
      next_r.status_drive_n = 1'b0;
      next_r.user           = 1'b0;
      next_r.error          = 1'b0;
    end else if (req_low && r.prev_req_n) begin
      next_r.cnt = '0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r       <= '0;
      r.state <= ST_HOLD;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------------------
  // word buffer
  // ----------------------------------------------------------------------------
  pcls_fifo #(
    .W    (WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .flush_i    (req_low),
    .in_data_i  (r.word),
    .in_valid_i (r.push),
    .in_ready_o (fifo_ready),
    .out_data_o (word_o),
    .out_valid_o(word_valid_o),
    .out_ready_i(word_ready_i)
  );

  assign status_n_o    = r.status_level;
  assign status_oe_n_o = r.status_drive_n;
  assign load_done_o   = r.done;
  assign user_mode_o   = r.user;
  assign load_error_o  = r.error;
endmodule

// file: pcls_loader_asserts.sv
// concurrent checks on the ports of the parallel configuration load sequencer
`timescale 1ns/10ps
module pcls_loader_asserts #(
  parameter int STATUS_MIN   = 13400,
  parameter int INIT_OSC     = 8750,
  parameter int STREAM_WORDS = 1024
) (
  input wire logic                 core_clk_i,
  input wire logic                 rstn_i,
  input wire logic                 cfg_req_n_i,
  input wire logic                 cfg_clock_i,
  input wire logic                 use_user_clock_i,
  input wire logic                 status_oe_n_o,
  input wire logic                 load_done_o,
  input wire logic                 user_mode_o,
  input wire logic                 load_error_o,
  input wire pcls_pkg::pcls_word_t word_o,
  input wire logic                 word_valid_o,
  input wire logic                 word_ready_i
);
  import pcls_pkg::*;
  int   rel_cnt;
  int   low_cnt;
  int   done_cnt;
  int   rise_cnt;
  logic clk_q;
  // ----
  // counters that stand in for long repetitions
  // ----
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rel_cnt  <= 0;
      low_cnt  <= 0;
      done_cnt <= 0;
      rise_cnt <= 0;
      clk_q    <= 1'b0;
    end else begin
      rel_cnt  <= (cfg_req_n_i && !status_oe_n_o && !load_error_o) ? rel_cnt + 1 : 0;
      low_cnt  <= !status_oe_n_o ? low_cnt + 1 : 0;
      done_cnt <= load_done_o ? done_cnt + 1 : 0;
      rise_cnt <= !cfg_req_n_i ? 0 : rise_cnt + int'(cfg_clock_i && !clk_q);
      clk_q    <= cfg_clock_i;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  a_req_done_low: assert property ($fell(cfg_req_n_i) |-> ##[1:4] !load_done_o)
    else $error("load-complete not cleared by request");
  a_req_status_low: assert property ($fell(cfg_req_n_i) |-> ##[1:4] !status_oe_n_o)
    else $error("status not pulled low by request");
  a_status_min_low: assert property ($rose(status_oe_n_o) |-> low_cnt >= STATUS_MIN - 2)
    else $error("status released too early");
  a_status_release: assert property (rel_cnt <= STATUS_MIN + 5)
    else $error("status not released after request");
  a_init_osc_time: assert property ($rose(user_mode_o) && !use_user_clock_i |->
    done_cnt >= INIT_OSC)
    else $error("user mode entered too early");
  a_done_word_count: assert property ($rose(load_done_o) |-> rise_cnt == STREAM_WORDS)
    else $error("load-complete with wrong word count");
  a_error_blocks_done: assert property (load_error_o |-> !load_done_o && !status_oe_n_o)
    else $error("error state with done or status released");
  a_user_exit: assert property ($fell(cfg_req_n_i) |-> ##[1:4] !user_mode_o)
    else $error("user mode kept after request");
  a_word_held: assert property (word_valid_o && !word_ready_i && cfg_req_n_i |=>
    word_valid_o && $stable(word_o))
    else $error("word dropped while stalled");
  c_done: cover property ($rose(load_done_o));
  c_user: cover property ($rose(user_mode_o));
  c_error: cover property ($rose(load_error_o));
endmodule
bind pcls_loader pcls_loader_asserts #(.STATUS_MIN(STATUS_MIN), .INIT_OSC(INIT_OSC),
  .STREAM_WORDS(STREAM_WORDS)) u_chk (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
  .cfg_req_n_i(cfg_req_n_i), .cfg_clock_i(cfg_clock_i), .use_user_clock_i(use_user_clock_i),
  .status_oe_n_o(status_oe_n_o), .load_done_o(load_done_o), .user_mode_o(user_mode_o),
  .load_error_o(load_error_o), .word_o(word_o), .word_valid_o(word_valid_o),
  .word_ready_i(word_ready_i));

// file: pcls_host_model.sv
// host model that drives the parallel configuration load pins
`timescale 1ns/10ps
module pcls_host_model (
  input  wire logic   core_clk_i,
  input  wire logic   status_n_i,
  output logic        req_n_o,
  output logic        cfg_clock_o,
  output logic [31:0] data_o
);
  initial begin
    req_n_o     = 1'b1;
    cfg_clock_o = 1'b0;
    data_o      = 32'h0;
  end
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  // a host that ignores the status wire waits a fixed, bench-scaled time instead
  localparam int BLIND_WAIT = 400;
  // tmo of zero: status wire not watched, so only the fixed wait protects the load
  task automatic request(input int tmo);
    req_n_o = 1'b0;
    idle(100);
    req_n_o = 1'b1;
    if (tmo == 0) begin
      idle(BLIND_WAIT);
    end else begin
      for (int i = 0; i < tmo && !status_n_i; i++) idle(1);
      idle(100);
    end
  endtask
  // 160 ns period; data inverted off the edge so stale values never match
  task automatic send(input logic [31:0] w);
    data_o = w;
    idle(4);
    cfg_clock_o = 1'b1;
    idle(2);
    // data moves while the clock is high, never in the step of the next word
    data_o = ~w;
    idle(2);
    cfg_clock_o = 1'b0;
  endtask
  task automatic two_falls();
    send(32'h0);
    send(32'h0);
  endtask
endmodule

// file: tb_top.sv
// self-checking bench for the parallel configuration load sequencer
`timescale 1ns/10ps
module tb_top;
  import pcls_pkg::*;
  localparam int SW = 20;
  localparam int UE = 8;
  logic        core_clk_i, rstn_i, ext_hold, uclk, use_uclk, drain, ready;
  logic        req_n, cfg_clock, st_n, st_oe_n, done, umode, err, wvalid, st_wire;
  logic [1:0]  width;
  logic [31:0] data;
  pcls_word_t  word;
  pcls_word_t  got[$];
  int          n_errors, compares, cyc;

  assign st_wire = (st_oe_n | st_n) & ~ext_hold;
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  pcls_host_model host (.core_clk_i(core_clk_i), .status_n_i(st_wire), .req_n_o(req_n),
    .cfg_clock_o(cfg_clock), .data_o(data));
  pcls_loader #(.STATUS_MIN(20), .INIT_OSC(10), .UCLK_EDGES(UE), .STREAM_WORDS(SW)) DUT (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .cfg_req_n_i(req_n), .cfg_clock_i(cfg_clock),
    .cfg_data_i(data), .bus_width_i(width), .status_n_i(st_wire), .status_n_o(st_n),
    .status_oe_n_o(st_oe_n), .load_done_o(done), .user_init_clock_i(uclk),
    .use_user_clock_i(use_uclk), .user_mode_o(umode), .load_error_o(err), .word_o(word),
    .word_valid_o(wvalid), .word_ready_i(ready));
  // the consumer stalls every other pair of cycles
  always @(negedge core_clk_i) ready <= drain & cyc[1];
  always @(posedge core_clk_i) begin
    if (wvalid && ready) got.push_back(word);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  function automatic logic [31:0] pat(input int i);
    return 32'ha5c3_0f96 ^ (32'(i) * 32'h0103_0507);
  endfunction
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (n_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic t_load(input logic [1:0] bw, input logic uc, input logic hold);
    logic [31:0] m;
    m = (bw == BW_8) ? MASK_8 : (bw == BW_16) ? MASK_16 : MASK_32;
    width = bw;
    use_uclk = uc;
    ext_hold = hold;
    drain = 1'b1;
    got.delete();
    fork
      host.request(3000);
      if (hold) begin
        repeat (300) @(negedge core_clk_i);
        check(34'(st_oe_n), 34'(1'b1));
        check(34'(st_wire), 34'(1'b0));
        ext_hold = 1'b0;
      end
    join
    check(34'(st_wire), 34'(1'b1));
    for (int i = 0; i < SW; i++) begin
      check(34'(done), 34'(1'b0));
      host.send(pat(i));
    end
    host.idle(2);
    check(34'(done), 34'(1'b1));
    for (int i = 0; i < 200 && got.size() < SW; i++) host.idle(1);
    check(34'(got.size()), 34'(SW));
    foreach (got[i]) check(got[i], {bw, pat(i) & m});
    host.two_falls();
    check(34'(umode), 34'(1'b0));
    if (uc) begin
      host.idle(40);
      check(34'(umode), 34'(1'b0));
      repeat (2 * UE - 2) begin
        host.idle(2);
        uclk = ~uclk;
      end
      host.idle(6);
      check(34'(umode), 34'(1'b0));
      repeat (4) begin
        host.idle(2);
        uclk = ~uclk;
      end
    end
    host.idle(30);
    check(34'(umode), 34'(1'b1));
  endtask
  // consumer held off: the buffer fills until a word is refused
  task automatic t_overrun();
    int n;
    drain = 1'b0;
    width = BW_32;
    got.delete();
    host.request(0);
    check(34'(st_wire), 34'(1'b1));
    n = 0;
    while (!err && n < SW) begin
      host.send(pat(n));
      n++;
    end
    host.idle(2);
    check(34'(n), 34'(FIFO_DEPTH + 2));
    check(34'({err, st_oe_n, done}), 34'(3'b100));
    drain = 1'b1;
    for (int i = 0; i < 300 && got.size() < FIFO_DEPTH + 1; i++) host.idle(1);
    host.idle(8);
    check(34'(got.size()), 34'(FIFO_DEPTH + 1));
    check(34'(wvalid), 34'(1'b0));
    foreach (got[i]) check(got[i], {BW_32, pat(i)});
  endtask
  // reset in user mode drops every output back to its reset level
  task automatic t_reset();
    rstn_i = 1'b0;
    host.idle(2);
    check(34'({st_oe_n, done, umode, err, wvalid}), 34'(5'b00000));
    rstn_i = 1'b1;
    host.idle(60);
    check(34'({st_wire, done, umode}), 34'(3'b100));
  endtask
  initial begin
    rstn_i = 1'b0;
    ext_hold = 1'b0;
    uclk = 1'b0;
    use_uclk = 1'b0;
    drain = 1'b0;
    ready = 1'b0;
    width = BW_8;
    cyc = 0;
    n_errors = 0;
    compares = 0;
    repeat (20) @(negedge core_clk_i);
    rstn_i = 1'b1;
    host.idle(60);
    check(34'({st_wire, done, umode}), 34'(3'b100));
    t_load(BW_8, 1'b0, 1'b1);
    t_load(BW_16, 1'b1, 1'b0);
    t_overrun();
    t_load(BW_32, 1'b0, 1'b0);
    t_reset();
    results();
  end
endmodule
